// >>> rtl/cbc_core_bus_interface.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Four transfer kinds: normal read, fast read, early write, late write.
// - Kind follows direction, addressed zone and programmed access type.
// - Normal read takes two cycles; fast read takes one cycle.
// - After reset reads are normal reads, with seven wait and three hold cycles.
// - Late write takes two cycles; early write takes three cycles.
// - After reset writes are early writes.
// - Wait cycles come right after the address cycle.
// - Hold cycles come at the end, data kept driven.
// - Write-timing register: 8-bit, read/write, at f900, resets to 07.
// - Early-write select: 0 gives late writes, 1 gives early writes.
// - Accesses route by address to flash, programming memory or I/O zone, each with its own settings.
// - Three-bit wait field adds zero to seven wait cycles; fast reads take none.
// - Two-bit hold field adds zero to three hold cycles; fast reads take none.
// - Fast-read enable set gives one-cycle reads, clear gives normal reads.
// - Post-idle set and zone change: exactly one extra idle cycle between transfers.
module cbc_core_bus_interface (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic core_req_i,
   input wire logic core_we_i,
   input wire logic [cbc_pkg::ADDR_W-1:0] core_addr_i,
   input wire logic [cbc_pkg::DATA_W-1:0] core_wdata_i,
   output logic core_busy_o,
   output logic core_done_o,
   output logic [cbc_pkg::DATA_W-1:0] core_rdata_o,
   output logic [1:0] mem_zone_o,
   output logic [cbc_pkg::ADDR_W-1:0] mem_addr_o,
   output logic [cbc_pkg::DATA_W-1:0] mem_wdata_o,
   output logic mem_active_o,
   output logic mem_rd_o,
   output logic mem_wr_o,
   input wire logic [cbc_pkg::DATA_W-1:0] mem_rdata_i,
   input wire logic [cbc_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [cbc_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [cbc_pkg::DATA_W-1:0] reg_rdata_o
);
   import cbc_pkg::*;

   logic [7:0] write_timing_config_ff;
   logic [DATA_W-1:0] io_zone_config_ff;
   logic [DATA_W-1:0] static_zone_zero_config_ff;
   logic [DATA_W-1:0] static_zone_one_config_ff;
   logic [DATA_W-1:0] reg_rdata_ff;
   logic [DATA_W-1:0] nxt_reg_rdata;

   cbc_state_e state_ff;
   cbc_state_e nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   cbc_zone_e zone_ff;
   cbc_zone_e req_zone;
   logic we_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [DATA_W-1:0] wdata_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic done_ff;
   logic finish;
   logic last_valid_ff;
   logic last_post_idle_select_ff;
   cbc_zone_e last_zone_ff;
   logic gap_need;

   logic [DATA_W-1:0] cfg;
   logic [2:0] cfg_wait;
   logic [1:0] cfg_hold;
   logic cfg_fast;
   logic early_wr;
   logic fast_rd;

   // Register port: reads answer one cycle later, unmapped reads give zero
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         write_timing_config_ff <= WTC_RST;
         io_zone_config_ff <= IOZ_RST;
         static_zone_zero_config_ff <= SZ_RST;
         static_zone_one_config_ff <= SZ_RST;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            REG_WTC_OFS: write_timing_config_ff <= reg_wdata_i[7:0] & WTC_MASK;
            REG_IOZ_OFS: io_zone_config_ff <= reg_wdata_i & IOZ_MASK;
            REG_SZ0_OFS: static_zone_zero_config_ff <= reg_wdata_i & SZ_MASK;
            REG_SZ1_OFS: static_zone_one_config_ff <= reg_wdata_i & SZ_MASK;
            default: ;
         endcase
      end
   end

   always_comb begin
      nxt_reg_rdata = '0;
      if (reg_rd_i) begin
         case (reg_addr_i)
            REG_WTC_OFS: nxt_reg_rdata = {8'h00, write_timing_config_ff};
            REG_IOZ_OFS: nxt_reg_rdata = io_zone_config_ff;
            REG_SZ0_OFS: nxt_reg_rdata = static_zone_zero_config_ff;
            REG_SZ1_OFS: nxt_reg_rdata = static_zone_one_config_ff;
            default: nxt_reg_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_ff <= '0;
      end else begin
         reg_rdata_ff <= nxt_reg_rdata;
      end
   end

   assign reg_rdata_o = reg_rdata_ff;

   // Zone decode of the core address
   always_comb begin
      if (core_addr_i >= ZONE_IO_BASE) begin
         req_zone = ZN_IO;
      end else if (core_addr_i >= ZONE_ISP_BASE) begin
         req_zone = ZN_ISP;
      end else begin
         req_zone = ZN_FLASH;
      end
   end

   // Settings of the zone being accessed
   always_comb begin
      case (zone_ff)
         ZN_IO: cfg = io_zone_config_ff;
         ZN_ISP: cfg = static_zone_one_config_ff;
         default: cfg = static_zone_zero_config_ff;
      endcase
   end

   assign cfg_wait = cfg[WAIT_LSB +: 3];
   assign cfg_hold = cfg[HOLD_LSB +: 2];
   // Fast read only where the zone has the enable
   assign cfg_fast = (zone_ff != ZN_IO) && cfg[FRE_BIT];
   // Kind chosen by direction, zone and programmed type
   assign fast_rd = !we_ff && cfg_fast;
   assign early_wr = write_timing_config_ff[EWR_BIT];

   // One idle cycle on zone change when the finished zone asks for it
   assign gap_need = last_valid_ff && last_post_idle_select_ff && (req_zone != last_zone_ff);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      finish = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (core_req_i) begin
               nxt_state = gap_need ? ST_GAP : ST_ADDR;
            end
         end
         ST_GAP: begin
            nxt_state = ST_ADDR;
         end
         ST_ADDR: begin
            if (fast_rd) begin
               // Fast read ends in the address cycle
               finish = 1'b1;
               nxt_state = ST_IDLE;
            end else if (cfg_wait != 3'h0) begin
               nxt_state = ST_WAIT;
               nxt_cnt = cfg_wait - 3'h1;
            end else begin
               nxt_state = ST_DATA;
            end
         end
         ST_WAIT: begin
            if (cnt_ff == 3'h0) begin
               nxt_state = ST_DATA;
            end else begin
               nxt_cnt = cnt_ff - 3'h1;
            end
         end
         ST_DATA: begin
            if (we_ff && early_wr) begin
               // Early write takes one more cycle
               nxt_state = ST_EXTRA;
            end else if (cfg_hold != 2'h0) begin
               nxt_state = ST_HOLD;
               nxt_cnt = {1'b0, cfg_hold - 2'h1};
            end else begin
               finish = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         ST_EXTRA: begin
            if (cfg_hold != 2'h0) begin
               nxt_state = ST_HOLD;
               nxt_cnt = {1'b0, cfg_hold - 2'h1};
            end else begin
               finish = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         ST_HOLD: begin
            if (cnt_ff == 3'h0) begin
               finish = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               nxt_cnt = cnt_ff - 3'h1;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= ST_IDLE;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // Request capture; address and data stay driven for the whole transfer
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         zone_ff <= ZN_FLASH;
         we_ff <= 1'b0;
         addr_ff <= '0;
         wdata_ff <= '0;
      end else if (state_ff == ST_IDLE && core_req_i) begin
         zone_ff <= req_zone;
         we_ff <= core_we_i;
         addr_ff <= core_addr_i;
         wdata_ff <= core_wdata_i;
      end
   end

   // Read data taken in the data cycle, or the address cycle when fast
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= '0;
      end else if (!we_ff && ((state_ff == ST_ADDR && fast_rd) || state_ff == ST_DATA)) begin
         rdata_ff <= mem_rdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= finish;
      end
   end

   // Zone and post-idle setting of the transfer just finished
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_valid_ff <= 1'b0;
         last_post_idle_select_ff <= 1'b0;
         last_zone_ff <= ZN_FLASH;
      end else if (finish) begin
         last_valid_ff <= 1'b1;
         last_post_idle_select_ff <= cfg[POST_IDLE_SELECT_BIT];
         last_zone_ff <= zone_ff;
      end
   end

   assign core_busy_o = (state_ff != ST_IDLE);
   assign core_done_o = done_ff;
   assign core_rdata_o = rdata_ff;
   assign mem_zone_o = zone_ff;
   assign mem_addr_o = addr_ff;
   assign mem_wdata_o = wdata_ff;
   assign mem_active_o = (state_ff != ST_IDLE) && (state_ff != ST_GAP);
   assign mem_rd_o = !we_ff && (state_ff == ST_ADDR || state_ff == ST_WAIT || state_ff == ST_DATA);
   assign mem_wr_o = we_ff && (state_ff == ST_DATA);

   // Checking helpers: expected and measured transfer length
   logic [LEN_W-1:0] exp_len_ff;
   logic [LEN_W-1:0] len_ff;
   logic [LEN_W-1:0] base_len;

   assign base_len = fast_rd ? LEN_W'(FAST_READ_CYC) : (!we_ff ? LEN_W'(NORMAL_READ_CYC) :
      (early_wr ? LEN_W'(EARLY_WRITE_CYC) : LEN_W'(LATE_WRITE_CYC)));

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         exp_len_ff <= '0;
         len_ff <= '0;
      end else if (state_ff == ST_ADDR) begin
         exp_len_ff <= fast_rd ? base_len : base_len + {1'b0, cfg_wait} + {2'b00, cfg_hold};
         len_ff <= LEN_W'(1);
      end else if (mem_active_o) begin
         len_ff <= len_ff + LEN_W'(1);
      end
   end

   sequence s_gap_then_addr;
      state_ff == ST_GAP ##1 state_ff == ST_ADDR;
   endsequence
   sequence s_early_write;
      state_ff == ST_DATA ##1 state_ff == ST_EXTRA ##1 done_ff;
   endsequence
   sequence s_two_cycle;
      state_ff == ST_DATA ##1 done_ff;
   endsequence

   chk_fast_read_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff == ST_ADDR && fast_rd |=> done_ff && state_ff == ST_IDLE)
      else $error("fast read did not end in one cycle");
   chk_normal_read_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff == ST_ADDR && !we_ff && !cfg_fast && cfg_wait == 3'h0 && cfg_hold == 2'h0 |=> s_two_cycle)
      else $error("normal read not two cycles");
   chk_late_write_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff == ST_ADDR && we_ff && !early_wr && cfg_wait == 3'h0 && cfg_hold == 2'h0 |=> s_two_cycle)
      else $error("late write not two cycles");
   chk_early_write_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff == ST_ADDR && we_ff && early_wr && cfg_wait == 3'h0 && cfg_hold == 2'h0 |=> s_early_write)
      else $error("early write not three cycles");
   // Waits and holds give the whole length
   chk_total_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(done_ff) |-> len_ff == exp_len_ff)
      else $error("transfer length differs from wait and hold settings");
   // Waits only after the address cycle
   chk_wait_after_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff == ST_WAIT |-> $past(state_ff) == ST_ADDR || $past(state_ff) == ST_WAIT)
      else $error("wait cycle not after address");
   // Data held steady through hold cycles
   chk_hold_data: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff == ST_HOLD |-> $stable(mem_wdata_o) && $stable(mem_addr_o) && mem_active_o)
      else $error("data moved during hold");
   // One idle cycle on a zone change only when the finished zone asks for it
   chk_post_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff == ST_IDLE && core_req_i && gap_need |=> s_gap_then_addr)
      else $error("post idle cycle missing");
   chk_no_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff == ST_IDLE && core_req_i && !gap_need |=> state_ff == ST_ADDR)
      else $error("unexpected idle cycle");
   // Reserved bits of write-timing register stay zero
   chk_wtc_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      reg_wr_i && reg_addr_i == REG_WTC_OFS |=> write_timing_config_ff == {5'h00, $past(reg_wdata_i[2:0])})
      else $error("write-timing register write wrong");
endmodule : cbc_core_bus_interface
`default_nettype wire

// >>> rtl/cbc_pkg.sv
package cbc_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int CNT_W = 3;
   localparam int LEN_W = 4;

   // Register offsets
   localparam logic [ADDR_W-1:0] REG_WTC_OFS = 16'hf900;
   localparam logic [ADDR_W-1:0] REG_IOZ_OFS = 16'hf902;
   localparam logic [ADDR_W-1:0] REG_SZ0_OFS = 16'hf904;
   localparam logic [ADDR_W-1:0] REG_SZ1_OFS = 16'hf906;

   // Reset values and writable-bit masks
   localparam logic [7:0] WTC_RST = 8'h07;
   localparam logic [7:0] WTC_MASK = 8'h07;
   localparam logic [DATA_W-1:0] IOZ_RST = 16'h069f;
   localparam logic [DATA_W-1:0] SZ_RST = 16'h069f;
   localparam logic [DATA_W-1:0] IOZ_MASK = 16'h029f;
   localparam logic [DATA_W-1:0] SZ_MASK = 16'h0e9f;

   // Field positions
   localparam int EWR_BIT = 0;
   localparam int WAIT_LSB = 0;
   localparam int HOLD_LSB = 3;
   localparam int BW_BIT = 7;
   localparam int POST_IDLE_SELECT_BIT = 9;
   localparam int FRE_BIT = 11;

   // Zone map of the core address space
   localparam logic [ADDR_W-1:0] ZONE_ISP_BASE = 16'hc000;
   localparam logic [ADDR_W-1:0] ZONE_IO_BASE = 16'hf000;

   // Basic cycle lengths
   localparam int FAST_READ_CYC = 1;
   localparam int NORMAL_READ_CYC = 2;
   localparam int LATE_WRITE_CYC = 2;
   localparam int EARLY_WRITE_CYC = 3;

   typedef enum logic [1:0] {ZN_FLASH, ZN_ISP, ZN_IO} cbc_zone_e;
   typedef enum logic [2:0] {ST_IDLE, ST_GAP, ST_ADDR, ST_WAIT, ST_DATA, ST_EXTRA, ST_HOLD} cbc_state_e;
endpackage : cbc_pkg

// >>> tb/cbc_zone_memory_model.sv
`timescale 1ns/100ps
`default_nettype none
module cbc_zone_memory_model (
   input wire logic ref_clk_i,
   input wire logic [1:0] mem_zone_i,
   input wire logic [cbc_pkg::ADDR_W-1:0] mem_addr_i,
   input wire logic [cbc_pkg::DATA_W-1:0] mem_wdata_i,
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   output logic [cbc_pkg::DATA_W-1:0] mem_rdata_o
);
   import cbc_pkg::*;
   logic [DATA_W-1:0] store [0:63];
   logic [DATA_W-1:0] last_ff;
   logic [5:0] idx;
   // Each zone keeps its own words
   assign idx = {mem_zone_i, mem_addr_i[3:0]};
   initial begin
      last_ff = 16'h0000;
      for (int i = 0; i < 64; i++) begin
         store[i] = 16'h1000 + 16'(i);
      end
   end
   always @(posedge ref_clk_i) begin
      if (mem_wr_i) begin
         store[idx] <= mem_wdata_i;
      end
      if (mem_rd_i) begin
         last_ff <= store[idx];
      end
   end
   // Released bus shows the inverse of the last word, never a stale copy
   assign mem_rdata_o = mem_rd_i ? store[idx] : ~last_ff;
endmodule : cbc_zone_memory_model
`default_nettype wire

// >>> tb/core_bus_cycle_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none
module core_bus_cycle_controller_tb;
   import cbc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic core_req = 1'b0;
   logic core_we = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] core_addr = 16'h0000;
   logic [15:0] core_wdata = 16'h0000;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic core_busy, core_done, mem_active, mem_rd, mem_wr;
   logic [15:0] core_rdata, mem_addr, mem_wdata, mem_rdata, reg_rdata;
   logic [1:0] mem_zone, prev_zone;
   logic [15:0] zcfg [0:2];
   logic [15:0] exp_mem [0:63];
   logic early_write_select, prev_post_idle_select;
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;

   cbc_core_bus_interface u_cbc_core_bus_interface (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .core_req_i(core_req), .core_we_i(core_we), .core_addr_i(core_addr), .core_wdata_i(core_wdata),
      .core_busy_o(core_busy), .core_done_o(core_done), .core_rdata_o(core_rdata), .mem_zone_o(mem_zone),
      .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_active_o(mem_active), .mem_rd_o(mem_rd),
      .mem_wr_o(mem_wr), .mem_rdata_i(mem_rdata), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
   cbc_zone_memory_model u_cbc_zone_memory_model (.ref_clk_i(ref_clk_i), .mem_zone_i(mem_zone),
      .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .mem_rd_i(mem_rd), .mem_wr_i(mem_wr),
      .mem_rdata_o(mem_rdata));

   initial begin
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         conclude();
      end
   end

   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task reg_write(input logic [15:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk_i);
      reg_wr <= 1'b0;
      case (a)
         REG_WTC_OFS: early_write_select = d[EWR_BIT];
         REG_IOZ_OFS: zcfg[2] = d & IOZ_MASK;
         REG_SZ0_OFS: zcfg[0] = d & SZ_MASK;
         REG_SZ1_OFS: zcfg[1] = d & SZ_MASK;
         default: ;
      endcase
   endtask : reg_write

   task reg_read(input logic [15:0] a, input logic [15:0] exp);
      @(posedge ref_clk_i);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk_i);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", reg_rdata, exp);
      @(posedge ref_clk_i);
      #1;
      check("reg_rdata after read", reg_rdata, 16'h0000);
   endtask : reg_read

   function automatic logic [1:0] zone_of(input logic [15:0] a);
      if (a >= ZONE_IO_BASE) return 2'h2;
      if (a >= ZONE_ISP_BASE) return 2'h1;
      return 2'h0;
   endfunction : zone_of

   task xfer(input logic we, input logic [15:0] a, input logic [15:0] d);
      logic [1:0] z;
      logic [15:0] cfg;
      logic fast_read_enable;
      int g, len, wr_at, n, act, bsy, rdc, rd_exp;
      z = zone_of(a);
      cfg = zcfg[z];
      g = (prev_post_idle_select && z != prev_zone) ? 1 : 0;
      fast_read_enable = (z != 2'h2) && cfg[FRE_BIT];
      len = (fast_read_enable && !we) ? 2 + g : 1 + g + (we ? (early_write_select ? 3 : 2) : 2) + int'(cfg[2:0]) + int'(cfg[4:3]);
      @(posedge ref_clk_i);
      core_req <= 1'b1;
      core_we <= we;
      core_addr <= a;
      core_wdata <= d;
      @(posedge ref_clk_i);
      core_req <= 1'b0;
      #1;
      rd_exp = we ? 0 : (fast_read_enable ? 1 : 2 + int'(cfg[2:0]));
      wr_at = 0;
      act = 0;
      bsy = 0;
      rdc = 0;
      for (n = 1; n < 64 && core_done !== 1'b1; n++) begin
         if (mem_wr === 1'b1 && wr_at == 0) wr_at = n;
         if (mem_active === 1'b1) act++;
         if (core_busy === 1'b1) bsy++;
         if (mem_rd === 1'b1) rdc++;
         @(posedge ref_clk_i);
         #1;
      end
      check("transfer length", 16'(n), 16'(len));
      check("busy cycles", 16'(bsy), 16'(len - 1));
      check("bus active cycles", 16'(act), 16'(len - 1 - g));
      check("core_busy at done", {15'h0000, core_busy}, 16'h0000);
      check("read strobe cycles", 16'(rdc), 16'(rd_exp));
      check("mem_zone", {14'h0000, mem_zone}, {14'h0000, z});
      check("mem_addr", mem_addr, a);
      if (we) begin
         check("write strobe cycle", 16'(wr_at), 16'(2 + g + int'(cfg[2:0])));
         check("held wdata", mem_wdata, d);
         exp_mem[{z, a[3:0]}] = d;
      end else begin
         check("core_rdata", core_rdata, exp_mem[{z, a[3:0]}]);
      end
      prev_zone = z;
      prev_post_idle_select = cfg[POST_IDLE_SELECT_BIT];
   endtask : xfer

   initial begin
      zcfg[0] = SZ_RST;
      zcfg[1] = SZ_RST;
      zcfg[2] = IOZ_RST;
      early_write_select = WTC_RST[EWR_BIT];
      prev_zone = 2'h0;
      prev_post_idle_select = 1'b0;
      for (int i = 0; i < 64; i++) exp_mem[i] = 16'h1000 + 16'(i);
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      reg_read(REG_WTC_OFS, 16'h0007);
      reg_read(REG_IOZ_OFS, 16'h069f);
      reg_read(REG_SZ0_OFS, 16'h069f);
      reg_read(REG_SZ1_OFS, 16'h069f);
      reg_read(16'hf908, 16'h0000);
      xfer(1'b0, 16'h0004, 16'h0000);
      xfer(1'b1, 16'h0004, 16'hbeef);
      xfer(1'b0, 16'h0004, 16'h0000);
      reg_write(16'hf908, 16'hffff);
      reg_read(16'hf908, 16'h0000);
      reg_write(REG_WTC_OFS, 16'h00ff);
      reg_read(REG_WTC_OFS, 16'h0007);
      reg_write(REG_WTC_OFS, 16'h0006);
      reg_read(REG_WTC_OFS, 16'h0006);
      for (int i = 0; i < 8; i++) begin
         reg_write(REG_SZ0_OFS, {11'h000, 2'(i), 3'(i)});
         xfer(1'b1, 16'(i), 16'h5a00 + 16'(i));
         xfer(1'b0, 16'(i), 16'h0000);
      end
      reg_write(REG_SZ0_OFS, 16'h0000);
      reg_write(REG_WTC_OFS, 16'h0007);
      xfer(1'b1, 16'h0009, 16'h1234);
      reg_write(REG_WTC_OFS, 16'h0006);
      reg_write(REG_SZ0_OFS, 16'h081f);
      xfer(1'b0, 16'h0009, 16'h0000);
      reg_write(REG_IOZ_OFS, 16'h081f);
      reg_read(REG_IOZ_OFS, 16'h001f);
      xfer(1'b0, 16'hf003, 16'h0000);
      reg_write(REG_SZ0_OFS, 16'h0200);
      reg_write(REG_SZ1_OFS, 16'h0000);
      xfer(1'b0, 16'h0001, 16'h0000);
      xfer(1'b1, 16'hc005, 16'h7e57);
      xfer(1'b0, 16'hc005, 16'h0000);
      xfer(1'b0, 16'h0002, 16'h0000);
      xfer(1'b0, 16'hf003, 16'h0000);
      conclude();
   end
endmodule : core_bus_cycle_controller_tb
`default_nettype wire
